/* pkg/ipm_map.vh */
`ifndef IPM_MAP_VH
`define IPM_MAP_VH

// Register byte offsets from the module base
`define IPM_ADDR_W        12
`define IPM_OFS_PENDING   12'h040
`define IPM_OFS_MASK      12'h044
`define IPM_OFS_PINLEVEL  12'h048
`define IPM_OFS_AUTOVECTOR_ENABLE      12'h04C
`define IPM_OFS_PINSTATE  12'h050

// Source field layout, shared by pending and mask
`define IPM_SRC_HI        17
`define IPM_SRC_LO        1
`define IPM_INT_LO        8
`define IPM_EXT_HI        7
`define IPM_SRC_W         17
`define IPM_MASK_RST      17'h1FFFF
`define IPM_PEND_RST      17'h00000

// External level positions inside the source field
`define IPM_LVL1          1
`define IPM_LVL2          2
`define IPM_LVL3          3
`define IPM_LVL4          4
`define IPM_LVL5          5
`define IPM_LVL6          6
`define IPM_LVL7          7

// Pin level assignment field
`define IPM_PAR_HI        7
`define IPM_PAR_LO        5
`define IPM_PAR_W         3
`define IPM_PAR_RST       3'h0
`define IPM_PAR_PIN5      2
`define IPM_PAR_PIN3      1
`define IPM_PAR_PIN1      0

// Autovector enable field
`define IPM_AUTOVECTOR_ENABLE_RST      7'h00

// Pin state register layout
`define IPM_PIN_W         4
`define IPM_PIN_SEVEN     3
`define IPM_PIN_FIVE      2
`define IPM_PIN_THREE     1
`define IPM_PIN_ONE       0

`endif

/* logic/ipm_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin levels
module ipm_sync #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         arst_n,
   input  wire [W-1:0] asyncIn,
   output wire [W-1:0] syncOut
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // First stage feeds only the second stage
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;

endmodule // ipm_sync

/* logic/ipm_ahb_slave.v */
`timescale 1ns/1ps
`include "ipm_map.vh"
// AHB-Lite slave front end: one wait state on every transfer
module ipm_ahb_slave (
   input  wire                   clk,
   input  wire                   arst_n,
   input  wire                   hsel,
   input  wire [31:0]            haddr,
   input  wire [1:0]             htrans,
   input  wire                   hwrite,
   input  wire [2:0]             hsize,
   input  wire                   hready,
   input  wire [31:0]            hwdata,
   output wire [31:0]            hrdata,
   output wire                   hreadyout,
   output wire                   hresp,
   output wire [`IPM_ADDR_W-1:0] regAddr,
   output wire                   regWrStb,
   output wire [31:0]            regWrData,
   input  wire [31:0]            regRdData
);

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_BUSY = 3'h2;
   localparam [2:0] ST_DONE = 3'h4;

   reg  [2:0]             state_q;
   reg  [2:0]             state_d;
   reg  [`IPM_ADDR_W-1:0] addr_q;
   reg                    write_q;
   reg  [31:0]            rdata_q;
   wire                   accept;

   // Only whole-word transfers are expected; hsize is not checked
   assign accept = hsel & htrans[1] & hready;

   always @* begin
      case (state_q)
         ST_IDLE: state_d = accept ? ST_BUSY : ST_IDLE;
         ST_BUSY: state_d = ST_DONE;
         ST_DONE: state_d = accept ? ST_BUSY : ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         addr_q  <= {`IPM_ADDR_W{1'b0}};
         write_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         if (accept && state_q != ST_BUSY) begin
            addr_q  <= {haddr[`IPM_ADDR_W-1:2], 2'h0};
            write_q <= hwrite;
         end
         // Registered read data, taken in the wait cycle
         if (state_q == ST_BUSY && !write_q) begin
            rdata_q <= regRdData;
         end
      end
   end

   assign regAddr   = addr_q;
   assign regWrStb  = (state_q == ST_BUSY) & write_q;
   assign regWrData = hwdata;
   assign hreadyout = (state_q != ST_BUSY);
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

endmodule // ipm_ahb_slave

/* logic/ipm_pending_mask.v */
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ipm_map.vh"
//
// Functional notes
// R1 - Mask bit set blocks source, clear enables
// R2 - Masked source still sets pending, no request
// R3 - Pending samples source signal every clock
// R4 - Pending read-only; mask readable and writable
// R5 - Bits 17..1 map DMA, UART, I2C, timers, watchdog, levels
// R6 - Pending 1 means pending; mask 1 means masked
// R7 - Core raises its mask level before masking
// R8 - Assignment register holds three selects at 7..5
// R9 - Select 2: pin five level 5 or 4
// R10 - Select 1: pin three level 3 or 6
// R11 - Select 0: pin one level 1 or 2
// R12 - Autovector enable valid only for assigned levels
// R13 - Reserved bits read zero, ignore writes
//
module ipm_pending_mask (
   input  wire                   clk,
   input  wire                   arst_n,
   // AHB-Lite register port
   input  wire                   hsel,
   input  wire [31:0]            haddr,
   input  wire [1:0]             htrans,
   input  wire                   hwrite,
   input  wire [2:0]             hsize,
   input  wire                   hready,
   input  wire [31:0]            hwdata,
   output wire [31:0]            hrdata,
   output wire                   hreadyout,
   output wire                   hresp,
   // Internal sources, bits 17..8, same clock
   input  wire [`IPM_SRC_HI:`IPM_INT_LO] internalInt,
   // External pins, asynchronous, active high after the pad
   input  wire                   extIntPinSeven,
   input  wire                   extIntPinFive,
   input  wire                   extIntPinThree,
   input  wire                   extIntPinOne,
   // Towards the core
   output wire [`IPM_SRC_HI:`IPM_SRC_LO] coreIntReq,
   output wire                   coreIntAny,
   output wire [`IPM_EXT_HI:`IPM_SRC_LO] autovectorActive
);

   // Bus front end
   wire [`IPM_ADDR_W-1:0] regAddr;
   wire                   regWrStb;
   wire [31:0]            regWrData;
   reg  [31:0]            regRdData;

   // Synchronised pins: {seven, five, three, one}
   wire [`IPM_PIN_W-1:0]  pinSync;
   wire                   pinSeven;
   wire                   pinFive;
   wire                   pinThree;
   wire                   pinOne;

   // Register state
   reg  [`IPM_SRC_HI:`IPM_SRC_LO] pending_q;
   reg  [`IPM_SRC_HI:`IPM_SRC_LO] mask_q;
   reg  [`IPM_SRC_HI:`IPM_SRC_LO] mask_d;
   reg  [`IPM_PAR_W-1:0]          pinLevel_q;
   reg  [`IPM_PAR_W-1:0]          pinLevel_d;
   reg  [`IPM_EXT_HI:`IPM_SRC_LO] autovector_enable_q;
   reg  [`IPM_EXT_HI:`IPM_SRC_LO] autovector_enable_d;

   // Derived vectors
   reg  [`IPM_EXT_HI:`IPM_SRC_LO] extLevel;
   reg  [`IPM_EXT_HI:`IPM_SRC_LO] levelEnabled;
   wire [`IPM_SRC_HI:`IPM_SRC_LO] srcVec;
   reg  [`IPM_SRC_HI:`IPM_SRC_LO] coreReq_q;
   reg                            coreAny_q;
   reg  [`IPM_EXT_HI:`IPM_SRC_LO] avecAct_q;
   // Request next value, shared by the vector and the summary
   wire [`IPM_SRC_HI:`IPM_SRC_LO] reqNext;
   wire [`IPM_EXT_HI:`IPM_SRC_LO] avecNext;

   // Register selects and write strobes
   wire                   selPending;
   wire                   selMask;
   wire                   selPinLevel;
   wire                   selAvec;
   wire                   selPinState;
   wire                   wrMask;
   wire                   wrPinLevel;
   wire                   wrAvec;

   // Register select, used by both the write and the read paths
   function hit;
      input [`IPM_ADDR_W-1:0] addr;
      input [`IPM_ADDR_W-1:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   ipm_ahb_slave uBus (
      .clk       (clk),
      .arst_n    (arst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .regAddr   (regAddr),
      .regWrStb  (regWrStb),
      .regWrData (regWrData),
      .regRdData (regRdData)
   );

   ipm_sync #(
      .W (`IPM_PIN_W)
   ) uPinSync (
      .clk     (clk),
      .arst_n  (arst_n),
      .asyncIn ({extIntPinSeven, extIntPinFive, extIntPinThree, extIntPinOne}),
      .syncOut (pinSync)
   );

   assign pinSeven = pinSync[`IPM_PIN_SEVEN];
   assign pinFive  = pinSync[`IPM_PIN_FIVE];
   assign pinThree = pinSync[`IPM_PIN_THREE];
   assign pinOne   = pinSync[`IPM_PIN_ONE];

   // Pin to level steering; a level with no pin stays quiet
   always @* begin
      extLevel = 7'h00;
      extLevel[`IPM_LVL7] = pinSeven;
      if (pinLevel_q[`IPM_PAR_PIN5]) begin
         extLevel[`IPM_LVL4] = pinFive; // R9
      end else begin
         extLevel[`IPM_LVL5] = pinFive; // R9
      end
      if (pinLevel_q[`IPM_PAR_PIN3]) begin
         extLevel[`IPM_LVL6] = pinThree; // R10
      end else begin
         extLevel[`IPM_LVL3] = pinThree; // R10
      end
      if (pinLevel_q[`IPM_PAR_PIN1]) begin
         extLevel[`IPM_LVL2] = pinOne; // R11
      end else begin
         extLevel[`IPM_LVL1] = pinOne; // R11
      end
   end

   // Levels that currently have a pin assigned to them
   always @* begin
      levelEnabled = 7'h00;
      levelEnabled[`IPM_LVL7] = 1'b1;
      levelEnabled[`IPM_LVL5] = ~pinLevel_q[`IPM_PAR_PIN5];
      levelEnabled[`IPM_LVL4] = pinLevel_q[`IPM_PAR_PIN5];
      levelEnabled[`IPM_LVL3] = ~pinLevel_q[`IPM_PAR_PIN3];
      levelEnabled[`IPM_LVL6] = pinLevel_q[`IPM_PAR_PIN3];
      levelEnabled[`IPM_LVL1] = ~pinLevel_q[`IPM_PAR_PIN1];
      levelEnabled[`IPM_LVL2] = pinLevel_q[`IPM_PAR_PIN1];
   end

   // Bits 17..8 internal modules, 7..1 external levels
   assign srcVec = {internalInt, extLevel}; // R5

   // One decode per register, shared by the write and the read paths
   assign selPending  = hit(regAddr, `IPM_OFS_PENDING);
   assign selMask     = hit(regAddr, `IPM_OFS_MASK);
   assign selPinLevel = hit(regAddr, `IPM_OFS_PINLEVEL);
   assign selAvec     = hit(regAddr, `IPM_OFS_AUTOVECTOR_ENABLE);
   assign selPinState = hit(regAddr, `IPM_OFS_PINSTATE);

   // Pending gets no strobe at all, so a bus write cannot reach it
   assign wrMask      = regWrStb & selMask; // R4
   assign wrPinLevel  = regWrStb & selPinLevel;
   assign wrAvec      = regWrStb & selAvec;

   // Whole source field written at once; no bit-set helpers
   always @* begin
      mask_d = mask_q;
      if (wrMask) begin
         mask_d = regWrData[`IPM_SRC_HI:`IPM_SRC_LO]; // R4 R13
      end
   end

   // Bits 4..0 have no storage, so they read back as zero
   always @* begin
      pinLevel_d = pinLevel_q;
      if (wrPinLevel) begin
         pinLevel_d = regWrData[`IPM_PAR_HI:`IPM_PAR_LO]; // R8 R13
      end
   end

   // Only bits 7..1 are stored; bit 0 is dropped
   always @* begin
      autovector_enable_d = autovector_enable_q;
      if (wrAvec) begin
         autovector_enable_d = regWrData[`IPM_EXT_HI:`IPM_SRC_LO]; // R13
      end
   end

   // Plain sample, not sticky: a dropped source clears its bit
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pending_q <= `IPM_PEND_RST;
      end else begin
         pending_q <= srcVec; // R3 R6
      end
   end

   // Everything starts masked until software opens a source
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= `IPM_MASK_RST;
      end else begin
         mask_q <= mask_d;
      end
   end

   // Steering changes reach pending one edge after the write
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinLevel_q <= `IPM_PAR_RST;
      end else begin
         pinLevel_q <= pinLevel_d;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         autovector_enable_q <= `IPM_AUTOVECTOR_ENABLE_RST;
      end else begin
         autovector_enable_q <= autovector_enable_d;
      end
   end

   // Pending stays visible; only the request is gated, bit by bit
   genvar src;
   generate
      for (src = `IPM_SRC_LO; src <= `IPM_SRC_HI; src = src + 1) begin : gGate
         assign reqNext[src] = pending_q[src] & ~mask_q[src]; // R1 R2 R6
      end
   endgenerate

   // An enable counts only where a pin currently feeds that level
   genvar lvl;
   generate
      for (lvl = `IPM_SRC_LO; lvl <= `IPM_EXT_HI; lvl = lvl + 1) begin : gAvec
         assign avecNext[lvl] = autovector_enable_q[lvl] & levelEnabled[lvl]; // R12
      end
   endgenerate

   // Registered so the core never sees a decode glitch
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         coreReq_q <= `IPM_PEND_RST;
      end else begin
         coreReq_q <= reqNext; // R1 R2
      end
   end

   // Built from the same next value, so it never lags the vector
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         coreAny_q <= 1'b0;
      end else begin
         coreAny_q <= |reqNext; // R1 R2
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         avecAct_q <= `IPM_AUTOVECTOR_ENABLE_RST;
      end else begin
         avecAct_q <= avecNext; // R12
      end
   end

   // Read mux; unmapped offsets and reserved bits read as zero
   always @* begin
      regRdData = 32'h00000000;
      if (selPending) begin
         regRdData[`IPM_SRC_HI:`IPM_SRC_LO] = pending_q; // R4 R13
      end
      if (selMask) begin
         regRdData[`IPM_SRC_HI:`IPM_SRC_LO] = mask_q; // R4 R13
      end
      if (selPinLevel) begin
         regRdData[`IPM_PAR_HI:`IPM_PAR_LO] = pinLevel_q; // R8
      end
      if (selAvec) begin
         regRdData[`IPM_EXT_HI:`IPM_SRC_LO] = autovector_enable_q;
      end
      // Raw synchronised pins, useful to check board wiring
      if (selPinState) begin
         regRdData[`IPM_PIN_W-1:0] = pinSync;
      end
   end

   // The core must lift its own mask level before software masks here
   assign coreIntReq       = coreReq_q; // R7
   assign coreIntAny       = coreAny_q;
   assign autovectorActive = avecAct_q;

endmodule // ipm_pending_mask

/* verification/ipm_pending_mask_props.sv */
`timescale 1ns/1ps
`include "ipm_map.vh"
module ipm_pending_mask_props (
   input wire         clk,
   input wire         arst_n,
   input wire         hsel,
   input wire [31:0]  haddr,
   input wire [1:0]   htrans,
   input wire         hwrite,
   input wire         hready,
   input wire         hreadyout,
   input wire         hresp,
   input wire [17:8]  internalInt,
   input wire         extIntPinSeven,
   input wire         extIntPinFive,
   input wire         extIntPinThree,
   input wire         extIntPinOne,
   input wire [17:1]  coreIntReq,
   input wire         coreIntAny,
   input wire [7:1]   autovectorActive
);
   logic maskWr_q;
   logic avecWr_q;
   wire  wrTake = hsel && htrans[1] && hready && hwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Sticky: set once software has issued a write to the register
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         maskWr_q <= 1'b0;
         avecWr_q <= 1'b0;
      end else begin
         maskWr_q <= maskWr_q | (wrTake && haddr[11:0] == `IPM_OFS_MASK);
         avecWr_q <= avecWr_q | (wrTake && haddr[11:0] == `IPM_OFS_AUTOVECTOR_ENABLE);
      end
   end
   int_src_a: assert property ((coreIntReq[17:8] & ~$past(internalInt, 2)) == 10'h0)
      else $error("request without internal source");
   any_req_a: assert property (coreIntAny == |coreIntReq)
      else $error("summary request mismatch");
   mask_rst_a: assert property (!maskWr_q |-> coreIntReq == 17'h0)
      else $error("request while mask at reset");
   autovector_enable_rst_a: assert property (!avecWr_q |-> autovectorActive == 7'h0)
      else $error("autovector active before enable");
   pin_seven_a: assert property (coreIntReq[7] |-> $past(extIntPinSeven, 4))
      else $error("level seven without pin");
   pin_five_a: assert property (coreIntReq[5] || coreIntReq[4] |-> $past(extIntPinFive, 4))
      else $error("level five or four without pin");
   pin_three_a: assert property (coreIntReq[3] || coreIntReq[6] |-> $past(extIntPinThree, 4))
      else $error("level three or six without pin");
   pin_one_a: assert property (coreIntReq[1] || coreIntReq[2] |-> $past(extIntPinOne, 4))
      else $error("level one or two without pin");
   bus_wait_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state wrong");
   resp_ok_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
endmodule // ipm_pending_mask_props
bind ipm_pending_mask ipm_pending_mask_props ipm_pending_mask_props_inst (.clk, .arst_n,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .internalInt,
   .extIntPinSeven, .extIntPinFive, .extIntPinThree, .extIntPinOne, .coreIntReq,
   .coreIntAny, .autovectorActive);

/* verification/ipm_core_model.sv */
`timescale 1ns/1ps
module ipm_core_model (
   input wire        clk,
   input wire        arst_n,
   input wire [17:1] coreIntReq,
   input wire        coreIntAny,
   input wire [2:0]  maskLvl,
   output logic      taken
);
   // Level seven cannot be held off by the status mask
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) taken <= 1'b0;
      else taken <= coreIntAny && (maskLvl < 3'h7 || coreIntReq[7]);
   end
endmodule // ipm_core_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "ipm_map.vh"
module tb_top;
   logic        clk = 0, arst_n = 0, hsel = 0, hwrite = 0, dataRd = 0, any, resp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, expQ[$];
   logic [1:0]  htrans = 0;
   logic [17:8] iInt = 0;
   logic [3:0]  pin = 0;
   logic [17:1] req, m;
   logic [7:1]  av;
   logic [2:0]  coreLvl = 0;
   logic [7:0]  lv;
   wire         hrdy;
   wire         coreTook;
   integer      fails = 0, total_checks = 0, i;
   always #5 clk = ~clk;
   ipm_pending_mask ipm_pending_mask_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(resp), .internalInt(iInt),
      .extIntPinSeven(pin[3]), .extIntPinFive(pin[2]), .extIntPinThree(pin[1]),
      .extIntPinOne(pin[0]), .coreIntReq(req), .coreIntAny(any), .autovectorActive(av));
   ipm_core_model ipm_core_model_inst (.clk(clk), .arst_n(arst_n), .coreIntReq(req),
      .coreIntAny(any), .maskLvl(coreLvl), .taken(coreTook));
   task test_done;
      if (fails == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, g, x);
      end
   endtask
   // Ready is judged at the falling edge, clear of the rising-edge updates
   task waitRdy;
      int k;
      logic ok;
      k = 0;
      do begin
         @(negedge clk);
         ok = hrdy;
         @(posedge clk);
         k++;
      end while (ok !== 1'b1 && k < 20);
      if (ok !== 1'b1) begin
         fails++;
         test_done;
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      if (!w) expQ.push_back(d);
      waitRdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy;
   endtask
   always @(posedge clk) begin
      if (dataRd && hrdy) chk(hrdata, expQ.pop_front());
      if (hrdy) dataRd <= hsel && htrans[1] && !hwrite;
   end
   initial begin
      i = $urandom(32'hE93C);
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      bus(0, `IPM_OFS_MASK, 32'h0003FFFE);
      bus(0, `IPM_OFS_PINLEVEL, 32'h0);
      bus(1, `IPM_OFS_PENDING, 32'hFFFFFFFF);
      bus(0, `IPM_OFS_PENDING, 32'h0);
      bus(1, 12'h0F0, 32'hFFFFFFFF);
      bus(0, 12'h0F0, 32'h0);
      coreLvl <= 3'h7;
      bus(1, `IPM_OFS_MASK, 32'hFFFFFFFF);
      bus(0, `IPM_OFS_MASK, 32'h0003FFFE);
      for (i = 0; i < 6; i++) begin
         m = 17'($urandom);
         iInt <= 10'($urandom);
         bus(1, `IPM_OFS_MASK, {14'h0, m, 1'b0});
         bus(0, `IPM_OFS_MASK, {14'h0, m, 1'b0});
         bus(0, `IPM_OFS_PENDING, {14'h0, iInt, 8'h0});
         @(negedge clk);
         chk(32'(req), 32'({iInt, 7'h0} & ~m));
         chk(32'(any), 32'(|({iInt, 7'h0} & ~m)));
         @(posedge clk);
      end
      iInt <= 10'h0;
      bus(1, `IPM_OFS_MASK, 32'h0);
      bus(1, `IPM_OFS_AUTOVECTOR_ENABLE, 32'hFFFFFFFF);
      pin <= 4'hF;
      for (i = 0; i < 8; i++) begin
         lv = 8'h80;
         lv[i[2] ? 4 : 5] = 1'b1;
         lv[i[1] ? 6 : 3] = 1'b1;
         lv[i[0] ? 2 : 1] = 1'b1;
         bus(1, `IPM_OFS_PINLEVEL, {24'h0, i[2:0], 5'h1F});
         bus(0, `IPM_OFS_PINLEVEL, {24'h0, i[2:0], 5'h00});
         repeat (4) @(posedge clk);
         bus(0, `IPM_OFS_PENDING, {24'h0, lv});
         @(negedge clk);
         chk(32'(av), 32'(lv[7:1]));
         chk(32'(req), 32'(lv[7:1]));
         chk(32'(coreTook), 32'h00000001);
         @(posedge clk);
      end
      bus(0, `IPM_OFS_PINSTATE, 32'h0000000F);
      bus(0, `IPM_OFS_AUTOVECTOR_ENABLE, 32'h000000FE);
      repeat (2) @(posedge clk);
      test_done;
   end
endmodule // tb_top
